//--- rtl/accel_status_pkg.sv
// Package with register map, field positions and reset values of the status block.
package accel_status_pkg;
  localparam logic [7:0] ADDR_DATA_STATUS = 8'h00;
  localparam logic [7:0] ADDR_OUT_X = 8'h01;
  localparam logic [7:0] ADDR_OUT_Y = 8'h03;
  localparam logic [7:0] ADDR_OUT_Z = 8'h05;
  localparam logic [7:0] ADDR_BUF_CTRL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h11;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h12;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h13;
  localparam logic [7:0] ADDR_INT_PIN_CTRL = 8'h2C;
  // Interrupt pin control fields.
  localparam int POL_HIGH_BIT = 1;
  localparam int OPEN_DRAIN_BIT = 0;
  localparam logic [7:0] INT_PIN_CTRL_RST = 8'h00;
  // Data status fields.
  localparam int ANY_DR_BIT = 3;
  localparam int ANY_OW_BIT = 7;
  localparam int OW_LSB = 4;
  localparam int NUM_AXES = 3;
  localparam int COUNT_W = 6;
  localparam int WMARK_BIT = 6;
  localparam int BOVF_BIT = 7;
  // Buffer control fields.
  localparam int BUF_EN_BIT = 0;
  // Interrupt status fields: data ready, overwrite, watermark.
  localparam int IRQ_W = 3;
  localparam int IRQ_DR_BIT = 0;
  localparam int IRQ_OW_BIT = 1;
  localparam int IRQ_WM_BIT = 2;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : accel_status_pkg

//--- rtl/axis_flags.sv
// Per-axis data-ready and overwrite flag keeper.
module axis_flags
  import accel_status_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Sample arrival and host read of the axis.
  input wire logic sample_new,
  input wire logic axis_read,
  // Flags.
  output logic ready_q,
  output logic overwrite_q
);

  // [RQ7] overwrite on unread
  // A new sample over an unread one is an overwrite.
  wire overwrite_hit = sample_new && ready_q;
  // [RQ10] read clears flags
  // New data always wins over a read in the same cycle.
  wire ready_d = sample_new ? 1'b1 : (axis_read ? 1'b0 : ready_q);
  wire overwrite_d = overwrite_hit ? 1'b1 : (axis_read ? 1'b0 : overwrite_q);

  // Flag registers.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ready_q <= 1'b0;
      overwrite_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      overwrite_q <= overwrite_d;
    end
  end

  // [RQ7] overwrite on unread
  AST_OW_SET: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ7]
    sample_new && ready_q |=> overwrite_q) else $error("Overwrite flag not set.");
  // [RQ10] read clears flags
  AST_READ_CLR: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ10]
    axis_read && !sample_new |=> !ready_q && !overwrite_q)
    else $error("Axis read did not clear flags.");
endmodule : axis_flags

//--- rtl/int_pin_drive.sv
// Interrupt pin driver with polarity and push-pull or open-drain mode.
module int_pin_drive (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Configuration and request.
  input wire logic irq_req,
  input wire logic pol_high,
  input wire logic open_drain,
  // Pin signals.
  output logic pin_o,
  output logic pin_oe
);

  // [RQ1] [RQ2] polarity level
  // Level that the pin takes when the interrupt is asserted.
  wire level_d = irq_req ? pol_high : !pol_high;
  // [RQ4] open drain release
  // Open drain drives only the active level and releases otherwise.
  wire oe_d = open_drain ? irq_req : 1'b1;

  // Pin registers; at reset the pin rests inactive low-active high.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_o <= 1'b1;
      pin_oe <= 1'b1;
    end else begin
      pin_o <= level_d;
      pin_oe <= oe_d;
    end
  end
endmodule : int_pin_drive

//--- rtl/accel_status.sv
// Accelerometer status register, interrupt pin control and event interrupt logic.
//
// Contract
// [RQ1] Active-low polarity: pin rests at 1, goes 0 when triggered.
// [RQ2] Active-high polarity: pin rests at 0, goes 1 when triggered.
// [RQ3] Push-pull drives both levels and is the reset default.
// [RQ4] Open drain drives only the active level and releases otherwise.
// [RQ5] Each axis has its own data-ready flag while new data is unread.
// [RQ6] Combined data-ready is set when any axis holds unread data.
// [RQ7] Per-axis overwrite flag when unread data gets replaced.
// [RQ8] Combined overwrite flag when any axis had an overwrite.
// [RQ9] With buffer enabled status shows count, watermark and overflow instead.
// [RQ10] Reading axis output clears that axis's ready and overwrite flags.
// [RQ11] Host reads status then flagged axes before the next sample.
//
// The implementer's own choice: the address-and-strobe port.
module accel_status
  import accel_status_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sample engine: one-cycle pulses per axis with the new data.
  input wire logic [NUM_AXES-1:0] sample_new,
  input wire logic [7:0] sample_x,
  input wire logic [7:0] sample_y,
  input wire logic [7:0] sample_z,
  // Sample buffer status.
  input wire logic [COUNT_W-1:0] buf_count,
  input wire logic buf_watermark,
  input wire logic buf_overflow,
  // Interrupt pins.
  output logic int1_o,
  output logic int1_oe,
  output logic int2_o,
  output logic int2_oe,
  // Level interrupt to the local processor.
  output logic irq
);

  logic [7:0] pin_ctrl_q;
  logic buf_en_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [7:0] out_x_q;
  logic [7:0] out_y_q;
  logic [7:0] out_z_q;
  logic [7:0] rdata_q;
  logic [NUM_AXES-1:0] ready_v;
  logic [NUM_AXES-1:0] ow_v;
  logic wm_prev_q;

  // Address decode of the register port.
  wire rd_x = reg_rd && (reg_addr == ADDR_OUT_X);
  wire rd_y = reg_rd && (reg_addr == ADDR_OUT_Y);
  wire rd_z = reg_rd && (reg_addr == ADDR_OUT_Z);
  wire rd_status = reg_rd && (reg_addr == ADDR_DATA_STATUS);
  wire wr_pin = reg_wr && (reg_addr == ADDR_INT_PIN_CTRL);
  wire wr_buf = reg_wr && (reg_addr == ADDR_BUF_CTRL);
  wire wr_ien = reg_wr && (reg_addr == ADDR_IRQ_ENABLE);
  wire wr_iclr = reg_wr && (reg_addr == ADDR_IRQ_CLEAR);
  wire [NUM_AXES-1:0] axis_rd = {rd_z, rd_y, rd_x};

  // Per-axis flag keepers.
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      // [RQ5] per-axis ready
      axis_flags u_flags (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .sample_new(sample_new[g]),
        .axis_read(axis_rd[g]),
        .ready_q(ready_v[g]),
        .overwrite_q(ow_v[g])
      );
    end
  endgenerate

  // [RQ6] combined ready
  wire any_ready = |ready_v;
  // [RQ8] combined overwrite
  wire any_ow = |ow_v;

  // [RQ9] status view select
  wire [7:0] rt_status = {any_ow, ow_v, any_ready, ready_v};
  wire [7:0] buf_status = {buf_overflow, buf_watermark, buf_count};
  wire [7:0] status_view = buf_en_q ? buf_status : rt_status;

  // Read data multiplexer; unmapped addresses read as zero.
  wire [7:0] rd_mux =
    (reg_addr == ADDR_DATA_STATUS) ? status_view :
    (reg_addr == ADDR_OUT_X) ? out_x_q :
    (reg_addr == ADDR_OUT_Y) ? out_y_q :
    (reg_addr == ADDR_OUT_Z) ? out_z_q :
    (reg_addr == ADDR_INT_PIN_CTRL) ? pin_ctrl_q :
    (reg_addr == ADDR_BUF_CTRL) ? {7'h00, buf_en_q} :
    (reg_addr == ADDR_IRQ_STATUS) ? {5'h00, irq_stat_q} :
    (reg_addr == ADDR_IRQ_ENABLE) ? {5'h00, irq_en_q} : ZERO_BYTE;

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_q <= ZERO_BYTE;
    end else begin
      rdata_q <= reg_rd ? rd_mux : ZERO_BYTE;
    end
  end
  assign reg_rdata = rdata_q;

  // Axis output data registers capture each new sample.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_x_q <= ZERO_BYTE;
      out_y_q <= ZERO_BYTE;
      out_z_q <= ZERO_BYTE;
    end else begin
      if (sample_new[0]) out_x_q <= sample_x;
      if (sample_new[1]) out_y_q <= sample_y;
      if (sample_new[2]) out_z_q <= sample_z;
    end
  end

  // Control registers.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // [RQ3] push-pull default
      pin_ctrl_q <= INT_PIN_CTRL_RST;
      buf_en_q <= 1'b0;
      irq_en_q <= '0;
    end else begin
      if (wr_pin) pin_ctrl_q <= reg_wdata;
      if (wr_buf) buf_en_q <= reg_wdata[BUF_EN_BIT];
      if (wr_ien) irq_en_q <= reg_wdata[IRQ_W-1:0];
    end
  end

  // Sticky event bits: a set in the same cycle wins over a clear.
  wire wm_rise = buf_watermark && !wm_prev_q;
  // Axes on which a new sample lands over unread data.
  wire [NUM_AXES-1:0] ow_hit_v = sample_new & ready_v;
  wire [IRQ_W-1:0] ev_set = {wm_rise, |ow_hit_v, |sample_new};
  wire [IRQ_W-1:0] ev_clr = wr_iclr ? reg_wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_stat_d = ev_set | (irq_stat_q & ~ev_clr);

  // Interrupt status registers.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq_stat_q <= '0;
      wm_prev_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      wm_prev_q <= buf_watermark;
    end
  end

  // Level interrupt for the local processor.
  wire irq_active = |(irq_stat_q & irq_en_q);
  assign irq = irq_active;

  wire pol_high = pin_ctrl_q[POL_HIGH_BIT];
  wire open_drain = pin_ctrl_q[OPEN_DRAIN_BIT];
  wire int2_req = irq_stat_q[IRQ_OW_BIT] && irq_en_q[IRQ_OW_BIT];

  // [RQ1] pin polarity drive
  int_pin_drive u_int1 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .irq_req(irq_active),
    .pol_high(pol_high),
    .open_drain(open_drain),
    .pin_o(int1_o),
    .pin_oe(int1_oe)
  );

  // [RQ2] pin polarity drive
  int_pin_drive u_int2 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .irq_req(int2_req),
    .pol_high(pol_high),
    .open_drain(open_drain),
    .pin_o(int2_o),
    .pin_oe(int2_oe)
  );

  // [RQ1] active-low pin level
  AST_POL_LOW: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ1]
    !pol_high && !open_drain |=> int1_o == !$past(irq_active))
    else $error("Active-low pin level wrong.");

  // [RQ1] active-low second pin
  AST_POL_LOW_INT2: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ1]
    !pol_high && !open_drain |=> int2_o == !$past(int2_req))
    else $error("Active-low second pin level wrong.");

  // [RQ2] active-high pin level
  AST_POL_HIGH: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ2]
    pol_high && !open_drain |=> int1_o == $past(irq_active))
    else $error("Active-high pin level wrong.");

  // [RQ2] active-high second pin
  AST_POL_HIGH_INT2: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ2]
    pol_high && !open_drain |=> int2_o == $past(int2_req))
    else $error("Active-high second pin level wrong.");

  // [RQ3] push-pull drives
  AST_PUSH_PULL: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ3]
    !open_drain |=> int1_oe && int2_oe)
    else $error("Push-pull pin released.");

  // [RQ3] push-pull reset rest
  AST_RESET_PINS: assert property (@(posedge clk_sys) // [RQ3]
    !resetn |=> !open_drain && int1_o && int1_oe && int2_o && int2_oe)
    else $error("Pins not at push-pull rest after reset.");

  // [RQ4] open drain release
  AST_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ4]
    open_drain && !irq_active |=> !int1_oe)
    else $error("Open-drain pin driven idle.");

  // [RQ4] open drain second pin
  AST_OPEN_DRAIN_INT2: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ4]
    open_drain && !int2_req |=> !int2_oe)
    else $error("Open-drain second pin driven idle.");

  // [RQ4] open drain pulls active
  AST_OPEN_DRAIN_PULL: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ4]
    open_drain && irq_active |=> int1_oe && int1_o == $past(pol_high))
    else $error("Open-drain pin not pulled to active level.");

  // [RQ4] open drain second pull
  AST_OPEN_DRAIN_PULL_INT2: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ4]
    open_drain && int2_req |=> int2_oe && int2_o == $past(pol_high))
    else $error("Open-drain second pin not pulled to active level.");

  // [RQ5] ready after sample
  AST_READY_SET: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ5]
    sample_new[0] |=> ready_v[0])
    else $error("X ready not set.");

  // [RQ5] ready on every axis
  AST_READY_SET_ALL: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ5]
    sample_new != '0 |=> (ready_v & $past(sample_new)) == $past(sample_new))
    else $error("Axis ready not set after sample.");

  // [RQ6] combined ready read
  AST_ANY_READY: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ6]
    rd_status && !buf_en_q |=> reg_rdata[ANY_DR_BIT] == ($past(ready_v) != '0))
    else $error("Combined ready wrong.");

  // [RQ7] overwrite per axis
  AST_OW_AXES: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ7]
    ow_hit_v != '0 |=> (ow_v & $past(ow_hit_v)) == $past(ow_hit_v))
    else $error("Axis overwrite flag not set.");

  // [RQ8] combined overwrite
  AST_ANY_OW: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ8]
    sample_new[1] && ready_v[1] |=> rt_status[ANY_OW_BIT])
    else $error("Combined overwrite missing.");

  // [RQ8] combined overwrite read
  AST_ANY_OW_READ: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ8]
    rd_status && !buf_en_q |=> reg_rdata[ANY_OW_BIT] == ($past(ow_v) != '0))
    else $error("Combined overwrite read wrong.");

  // [RQ9] real-time view
  AST_RT_FIELDS: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ9]
    rd_status && !buf_en_q
    |=> reg_rdata[NUM_AXES-1:0] == $past(ready_v)
    && reg_rdata[OW_LSB +: NUM_AXES] == $past(ow_v))
    else $error("Real-time status fields wrong.");

  // [RQ9] buffer view
  AST_BUF_VIEW: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ9]
    rd_status && buf_en_q
    |=> reg_rdata[BOVF_BIT] == $past(buf_overflow)
    && reg_rdata[WMARK_BIT] == $past(buf_watermark))
    else $error("Buffer status view wrong.");

  // [RQ9] buffer count view
  AST_BUF_COUNT: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ9]
    rd_status && buf_en_q |=> reg_rdata[COUNT_W-1:0] == $past(buf_count))
    else $error("Buffer count view wrong.");

  // [RQ10] Y read clears
  AST_READ_CLR_Y: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ10]
    rd_y && !sample_new[1] |=> !ready_v[1] && !ow_v[1])
    else $error("Y read did not clear flags.");

  // [RQ10] Z read clears
  AST_READ_CLR_Z: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ10]
    rd_z && !sample_new[2] |=> !ready_v[2] && !ow_v[2])
    else $error("Z read did not clear flags.");

  // A sample event is kept even when a clear lands in the same cycle.
  AST_STICKY_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
    sample_new != '0 |=> irq_stat_q[IRQ_DR_BIT])
    else $error("Data-ready event bit not set.");

  // A clear with no event in the same cycle empties the event bit.
  AST_IRQ_CLR: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_iclr && reg_wdata[IRQ_DR_BIT] && sample_new == '0 |=> !irq_stat_q[IRQ_DR_BIT])
    else $error("Data-ready event bit not cleared.");

  // Read data rest at zero outside the cycle after a read.
  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    !reg_rd |=> reg_rdata == ZERO_BYTE)
    else $error("Read data not idle.");
endmodule : accel_status

//--- dv/host_line_model.sv
// Host side of the interrupt line: a resistor pulls the line when no pin drives it.
module host_line_model (
  // Pin from the device.
  input wire logic pin_o,
  input wire logic pin_oe,
  // Level of the resistor on the line.
  input wire logic pull_lvl,
  // Level that the host sees.
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // released line
  // A released pin leaves the line to the resistor, so the host never sees a held value.
  assign line = pin_oe ? pin_o : pull_lvl;
endmodule : host_line_model

//--- dv/test_accel_status.sv
// Self-checking testbench for the accelerometer status block.
module test_accel_status;
  import accel_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, pol_b = 0, od_b = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, sample_x = 0, sample_y = 0, sample_z = 0;
  logic [NUM_AXES-1:0] sample_new = 0;
  logic [COUNT_W-1:0] buf_count = 0;
  logic buf_watermark = 0, buf_overflow = 0;
  logic [7:0] reg_rdata, v, bv;
  logic int1_o, int1_oe, int2_o, int2_oe, irq, line1;
  logic [2:0] dr_m = 0, ow_m = 0;
  logic [7:0] last_m [3];
  int n_errors = 0, samples_checked = 0, seed = 96269;

  // Clock at 25 MHz.
  always #20 clk_sys = ~clk_sys;

  accel_status accel_status_i (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_new(sample_new), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
    .buf_count(buf_count), .buf_watermark(buf_watermark), .buf_overflow(buf_overflow),
    .int1_o(int1_o), .int1_oe(int1_oe), .int2_o(int2_o), .int2_oe(int2_oe), .irq(irq));
  host_line_model host_line_model_i (.pin_o(int1_o), .pin_oe(int1_oe), .pull_lvl(~pol_b),
    .line(line1));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Expected real-time status byte from the kept flags.
  function automatic logic [7:0] exp_status();
    return {|ow_m, ow_m, |dr_m, dr_m};
  endfunction : exp_status

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd

  // Sends one sample pulse and keeps the expected flags.
  task automatic pulse(input logic [2:0] m);
    logic [7:0] s [3];
    for (int i = 0; i < 3; i++) begin
      s[i] = 8'($random(seed));
      ow_m[i] = ow_m[i] | (dr_m[i] & m[i]);
      dr_m[i] = dr_m[i] | m[i];
      if (m[i]) last_m[i] = s[i];
    end
    @(posedge clk_sys);
    sample_new <= m;
    sample_x <= s[0];
    sample_y <= s[1];
    sample_z <= s[2];
    @(posedge clk_sys);
    sample_new <= 3'h0;
  endtask : pulse

  task automatic rdax(input int i);
    rd(ADDR_OUT_X + 8'(2 * i), v);
    chk(v, last_m[i]);
    dr_m[i] = 1'h0;
    ow_m[i] = 1'h0;
  endtask : rdax

  task automatic pins(input logic act);
    repeat (2) @(posedge clk_sys);
    #1 chk({3'h0, irq, line1, int1_oe, int2_o, int2_oe}, {3'h0, act, act ~^ pol_b, ~od_b | act,
      act ~^ pol_b, ~od_b | act});
  endtask : pins

  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Cuts a hang short.
  initial begin
    #(40 * 20000);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'h1;
    #1 chk({6'h00, int1_o, int1_oe}, 8'h03);
    rd(ADDR_INT_PIN_CTRL, v);
    chk(v, INT_PIN_CTRL_RST);
    rd(8'h3F, v);
    chk(v, 8'h00);
    pulse(3'h7);
    pulse(3'h7);
    rd(ADDR_DATA_STATUS, v);
    chk(v, 8'hFF);
    for (int n = 0; n < 60; n++) begin
      pulse(3'($random(seed)));
      if (n % 2 == 0) rdax({$random(seed)} % 3);
      rd(ADDR_DATA_STATUS, v);
      chk(v, exp_status());
    end
    wr(ADDR_BUF_CTRL, 8'h01);
    rd(ADDR_BUF_CTRL, v);
    chk(v, 8'h01);
    repeat (6) begin
      bv = 8'($random(seed));
      @(posedge clk_sys);
      buf_count <= bv[5:0];
      buf_watermark <= bv[6];
      buf_overflow <= bv[7];
      rd(ADDR_DATA_STATUS, v);
      chk(v, bv);
    end
    wr(ADDR_BUF_CTRL, 8'h00);
    // Watermark rise after a clear sets only the watermark event bit.
    @(posedge clk_sys);
    buf_watermark <= 1'h0;
    wr(ADDR_IRQ_CLEAR, 8'h07);
    buf_watermark <= 1'h1;
    rd(ADDR_IRQ_STATUS, v);
    chk(v, 8'h04);
    for (int m = 0; m < 4; m++) begin
      {pol_b, od_b} = 2'(m);
      wr(ADDR_IRQ_CLEAR, 8'h07);
      wr(ADDR_IRQ_ENABLE, 8'h03);
      wr(ADDR_INT_PIN_CTRL, 8'(m));
      pins(1'h0);
      pulse(3'h1);
      pulse(3'h1);
      pins(1'h1);
      rd(ADDR_IRQ_STATUS, v);
      chk(v, 8'h03);
      rd(ADDR_IRQ_ENABLE, v);
      chk(v, 8'h03);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      pins(1'h0);
      wr(ADDR_IRQ_ENABLE, 8'h03);
      pins(1'h1);
      wr(ADDR_IRQ_CLEAR, 8'h07);
      pins(1'h0);
      rd(ADDR_IRQ_STATUS, v);
      chk(v, 8'h00);
      // host read order
      // Host reads status, then the flagged axis.
      rd(ADDR_DATA_STATUS, v);
      chk(v, exp_status());
      rdax(0);
    end
    // A reset in mid-run returns the flags and the pins to rest.
    @(posedge clk_sys);
    resetn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'h1;
    {pol_b, od_b} = 2'h0;
    dr_m = 3'h0;
    ow_m = 3'h0;
    pins(1'h0);
    rd(ADDR_DATA_STATUS, v);
    chk(v, exp_status());
    test_done();
  end
endmodule : test_accel_status
